// file: rtl/bridge_control_config_regs.sv
// bridge control and upper configuration registers behind an apb slave
// assumes a same-clock apb master, eeprom loader and decode requester;
// serr and parity pins arrive from the secondary bus unsynchronised
//
// Notes on behaviour
// R1: io limit bits 31:16 read/write, reset zero
// R2: capability pointer reads fixed dch
// R3: interrupt pin register reads zero
// R4: parity enable bit gates secondary parity reporting
// R5: forward secondary serr only when enabled
// R6: isa mode blocks downstream last 768 bytes
// R7: isa mode forwards upstream last 768 bytes
// R8: eeprom write protect freezes isa bit
// R9: vga enable forwards vga addresses downstream
// R10: abort mode clear hides master abort
// R11: abort mode set gives target abort
// R12: locked master aborts always target abort
// R13: secondary reset bit holds reset output
// R14: never fast back-to-back, bit reads zero
// R15: record received master abort status
// R16: configuration writes to read-only fields ignored
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ns
`include "bridge_ctrl_map.svh"

module bridge_control_config_regs
  import bridge_ctrl_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt
  output logic irq,
  // eeprom loader results
  input wire logic eeprom_load_enable,
  input wire logic eeprom_isa_write_protect,
  // secondary bus pins
  input wire logic secondary_system_error_in_n,
  input wire logic secondary_parity_error_n,
  output logic primary_system_error_out_n,
  output logic secondary_reset_output_n,
  // forwarding decode request
  input wire logic dec_valid,
  input wire logic dec_is_io,
  input wire logic dec_upstream,
  input wire logic [31:0] dec_addr,
  input wire logic [31:0] io_base_addr,
  input wire logic [3:0] io_limit_low,
  output logic dec_done,
  output logic dec_forward,
  // secondary master abort report
  input wire logic sec_mabort,
  input wire logic sec_mabort_read,
  input wire logic sec_mabort_locked,
  output logic abort_target,
  output logic abort_fill,
  output logic abort_discard,
  output logic [31:0] abort_fill_data
);

  if (ADDR_W < 10 || ADDR_W > 32)
  begin : g_bad_addr_w
    $error("ADDR_W must lie between 10 and 32");
  end

  typedef struct packed {
    word_t prdata;
    logic pready;
    logic pslverr;
    logic irq;
    half_t io_limit_upper;
    half_t bridge_ctrl;
    event_t ev_status;
    event_t ev_mask;
    logic serr_s1;
    logic serr_s2;
    logic par_s1;
    logic par_s2;
    logic par_s3;
    logic pserr_n;
    logic srst_n;
    logic dec_done;
    logic dec_forward;
    logic ab_target;
    logic ab_fill;
    logic ab_discard;
    word_t ab_data;
  } state_t;

  state_t r;
  state_t n;

  logic [ADDR_W-3:0] widx;
  logic setup_ph;
  logic write_go;
  logic hit_limit;
  logic hit_cap;
  logic hit_pin;
  logic hit_bc;
  logic hit_st;
  logic hit_mk;
  logic mapped;
  logic isa_locked;
  logic in_window;
  logic isa_alias;
  logic vga_hit;
  logic mode_report;
  event_t ev_set;
  word_t rd_word;
  word_t io_limit_full;
  half_t bc_keep;

  assign widx = paddr[ADDR_W-1:2];

  always_comb
  begin
    n = r;
    setup_ph = psel && !penable;
    write_go = psel && penable && r.pready && pwrite;
    hit_limit = 1'b0;
    hit_cap = 1'b0;
    hit_pin = 1'b0;
    hit_bc = 1'b0;
    hit_st = 1'b0;
    hit_mk = 1'b0;
    if (widx == (ADDR_W-2)'(`IO_LIMIT_UPPER_IDX))
    begin
      hit_limit = 1'b1;
    end
    else if (widx == (ADDR_W-2)'(`CAP_PTR_IDX))
    begin
      hit_cap = 1'b1;
    end
    else if (widx == (ADDR_W-2)'(`INT_PIN_IDX))
    begin
      hit_pin = 1'b1;
    end
    else if (widx == (ADDR_W-2)'(`BRIDGE_CTRL_IDX))
    begin
      hit_bc = 1'b1;
    end
    else if (widx == (ADDR_W-2)'(`EVENT_STATUS_IDX))
    begin
      hit_st = 1'b1;
    end
    else if (widx == (ADDR_W-2)'(`EVENT_MASK_IDX))
    begin
      hit_mk = 1'b1;
    end
    mapped = hit_limit | hit_cap | hit_pin | hit_bc | hit_st | hit_mk;

    // read data selection
    rd_word = '0;
    if (hit_limit)
    begin
      // R1: limit upper read
      rd_word = {16'h0000, r.io_limit_upper};
    end
    else if (hit_cap)
    begin
      // R2: fixed capability pointer
      rd_word = {24'h000000, `CAP_PTR_VALUE};
    end
    else if (hit_pin)
    begin
      // R3: no interrupt pin
      rd_word = {24'h000000, `INT_PIN_VALUE};
    end
    else if (hit_bc)
    begin
      // R14: fast back-to-back reads zero
      rd_word = {16'h0000, r.bridge_ctrl & `BC_WRITE_MASK};
    end
    else if (hit_st)
    begin
      rd_word = {29'h0, r.ev_status};
    end
    else if (hit_mk)
    begin
      rd_word = {29'h0, r.ev_mask};
    end

    // apb answer one cycle after setup
    n.pready = setup_ph && !r.pready;
    if (setup_ph)
    begin
      n.prdata = pwrite ? 32'h0000_0000 : rd_word;
      n.pslverr = !mapped;
    end
    else if (psel && penable && r.pready)
    begin
      n.prdata = 32'h0000_0000;
      n.pslverr = 1'b0;
    end

    // R8: eeprom write protect on isa bit
    isa_locked = eeprom_load_enable && eeprom_isa_write_protect;
    bc_keep = ~`BC_WRITE_MASK;
    if (isa_locked)
    begin
      bc_keep[`BC_ISA_BIT] = 1'b1;
    end

    if (write_go)
    begin
      // R16: read-only fields ignore writes
      if (hit_limit)
      begin
        // R1: limit upper write
        n.io_limit_upper = pwdata[15:0];
      end
      else if (hit_bc)
      begin
        // R14: bit 7 never stored
        n.bridge_ctrl = (pwdata[15:0] & ~bc_keep) | (r.bridge_ctrl & bc_keep);
      end
      else if (hit_mk)
      begin
        n.ev_mask = pwdata[2:0];
      end
    end

    // pin synchronisers
    n.serr_s1 = ~secondary_system_error_in_n;
    n.serr_s2 = r.serr_s1;
    n.par_s1 = ~secondary_parity_error_n;
    n.par_s2 = r.par_s1;
    n.par_s3 = r.par_s2;

    // R5: serr forwarding gate
    n.pserr_n = ~(r.serr_s2 && r.bridge_ctrl[`BC_SERR_BIT]);
    // R13: forced secondary reset
    n.srst_n = ~r.bridge_ctrl[`BC_SRST_BIT];

    // event sources
    ev_set = '0;
    // R4: parity detection gated
    ev_set[`EV_PARITY_BIT] = r.par_s2 && !r.par_s3 && r.bridge_ctrl[`BC_PARITY_BIT];
    ev_set[`EV_SERR_BIT] = r.serr_s2 && r.bridge_ctrl[`BC_SERR_BIT];
    // R15: received master abort
    ev_set[`EV_MABORT_BIT] = sec_mabort;
    // set wins over write-one-clear
    if (write_go && hit_st)
    begin
      n.ev_status = (r.ev_status & ~pwdata[2:0]) | ev_set;
    end
    else
    begin
      n.ev_status = r.ev_status | ev_set;
    end
    n.irq = |(n.ev_status & r.ev_mask);

    // forwarding decode
    io_limit_full = {r.io_limit_upper, io_limit_low, `IO_LOW_FILL};
    in_window = (dec_addr >= io_base_addr) && (dec_addr <= io_limit_full);
    isa_alias = r.bridge_ctrl[`BC_ISA_BIT] && (dec_addr < `ISA_SPACE_END) && (dec_addr[9:8] != 2'b00);
    vga_hit = 1'b0;
    if (dec_is_io)
    begin
      vga_hit = ((dec_addr >= `VGA_IO1_LO) && (dec_addr <= `VGA_IO1_HI))
        || ((dec_addr >= `VGA_IO2_LO) && (dec_addr <= `VGA_IO2_HI));
    end
    else
    begin
      vga_hit = (dec_addr >= `VGA_MEM_LO) && (dec_addr <= `VGA_MEM_HI);
    end
    n.dec_done = dec_valid;
    n.dec_forward = 1'b0;
    if (dec_valid)
    begin
      if (!dec_upstream && r.bridge_ctrl[`BC_VGA_BIT] && vga_hit)
      begin
        // R9: vga forwarded regardless
        n.dec_forward = 1'b1;
      end
      else if (!dec_upstream && dec_is_io)
      begin
        // R6: isa alias blocked downstream
        n.dec_forward = in_window && !isa_alias;
      end
      else if (dec_upstream && dec_is_io)
      begin
        // R7: isa alias forwarded upstream
        n.dec_forward = !in_window || isa_alias;
      end
    end

    // master abort response
    mode_report = r.bridge_ctrl[`BC_MA_MODE_BIT];
    n.ab_target = 1'b0;
    n.ab_fill = 1'b0;
    n.ab_discard = 1'b0;
    n.ab_data = 32'h0000_0000;
    if (sec_mabort)
    begin
      if (sec_mabort_locked)
      begin
        // R12: locked cycles target abort
        n.ab_target = 1'b1;
      end
      else if (mode_report)
      begin
        // R11: report as target abort
        n.ab_target = 1'b1;
      end
      else if (sec_mabort_read)
      begin
        // R10: reads return all ones
        n.ab_fill = 1'b1;
        n.ab_data = `ALL_ONES;
      end
      else
      begin
        // R10: write data discarded
        n.ab_discard = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r <= '0;
      r.io_limit_upper <= `IO_LIMIT_UPPER_RST;
      r.bridge_ctrl <= `BRIDGE_CTRL_RST;
      r.ev_status <= `EVENT_RST;
      r.ev_mask <= `EVENT_RST;
      r.pserr_n <= 1'b1;
      r.srst_n <= 1'b1;
    end
    else
    begin
      r <= n;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign irq = r.irq;
  assign primary_system_error_out_n = r.pserr_n;
  assign secondary_reset_output_n = r.srst_n;
  assign dec_done = r.dec_done;
  assign dec_forward = r.dec_forward;
  assign abort_target = r.ab_target;
  assign abort_fill = r.ab_fill;
  assign abort_discard = r.ab_discard;
  assign abort_fill_data = r.ab_data;

endmodule

// file: rtl/bridge_ctrl_map.svh
// constants of the bridge control configuration block
// assumes 32-bit apb words, byte address = 4 * register index
`ifndef BRIDGE_CTRL_MAP_SVH
`define BRIDGE_CTRL_MAP_SVH
`define IO_LIMIT_UPPER_IDX 8'h32
`define CAP_PTR_IDX 8'h34
`define INT_PIN_IDX 8'h3d
`define BRIDGE_CTRL_IDX 8'h3e
`define EVENT_STATUS_IDX 8'h60
`define EVENT_MASK_IDX 8'h61
`define IO_LIMIT_UPPER_RST 16'h0000
`define CAP_PTR_VALUE 8'hdc
`define INT_PIN_VALUE 8'h00
`define BRIDGE_CTRL_RST 16'h0000
`define BC_PARITY_BIT 0
`define BC_SERR_BIT 1
`define BC_ISA_BIT 2
`define BC_VGA_BIT 3
`define BC_MA_MODE_BIT 5
`define BC_SRST_BIT 6
`define BC_WRITE_MASK 16'h006f
`define EV_PARITY_BIT 0
`define EV_SERR_BIT 1
`define EV_MABORT_BIT 2
`define EVENT_RST 3'h0
`define ISA_SPACE_END 32'h0001_0000
`define VGA_MEM_LO 32'h000a_0000
`define VGA_MEM_HI 32'h000b_ffff
`define VGA_IO1_LO 32'h0000_03b0
`define VGA_IO1_HI 32'h0000_03bb
`define VGA_IO2_LO 32'h0000_03c0
`define VGA_IO2_HI 32'h0000_03df
`define ALL_ONES 32'hffff_ffff
`define IO_LOW_FILL 12'hfff
`endif

// file: rtl/bridge_ctrl_pkg.sv
// types of the bridge control configuration block
// assumes nothing beyond the constants header
package bridge_ctrl_pkg;
  typedef logic [31:0] word_t;
  typedef logic [15:0] half_t;
  typedef logic [2:0] event_t;
endpackage

// file: test/bridge_control_config_regs_bench.sv
// bench: random and corner stimulus on the bridge control block
// assumes the checker bind and the bus model
`timescale 1ns/1ns
module bridge_control_config_regs_bench import bridge_ctrl_pkg::*;;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ee = 0, serr_on = 0, perr_go = 0;
  logic abort_go = 0, dec_valid = 0, dec_is_io = 0, dec_upstream = 0, pready, pslverr, irq, pse_n, srst_n;
  logic dec_done, dec_forward, serr_n, perr_n, ma, a_t, a_f, a_d;
  logic [1:0] abort_kind = 0, mq;
  logic [11:0] paddr = 0;
  word_t pwdata = 0, dec_addr = 0, io_base = 0, prdata, rv, fd, wd;
  int n_mismatch = 0, check_count = 0, seed = 2422, i;
  localparam logic [11:0] ra [4] = '{12'hc8, 12'hd0, 12'hf4, 12'hf8};
  localparam word_t rst_v [4] = '{32'h0, 32'hdc, 32'h0, 32'h0};
  localparam word_t ones_v [4] = '{32'hffff, 32'hdc, 32'h0, 32'h6f};
  initial forever #5 pclk = !pclk;
  bridge_control_config_regs #(.ADDR_W(12)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .irq, .eeprom_load_enable(ee), .eeprom_isa_write_protect(ee),
    .secondary_system_error_in_n(serr_n), .secondary_parity_error_n(perr_n),
    .primary_system_error_out_n(pse_n), .secondary_reset_output_n(srst_n), .dec_valid, .dec_is_io,
    .dec_upstream, .dec_addr, .io_base_addr(io_base), .io_limit_low(4'hf), .dec_done, .dec_forward,
    .sec_mabort(ma), .sec_mabort_read(mq[0]), .sec_mabort_locked(mq[1]), .abort_target(a_t),
    .abort_fill(a_f), .abort_discard(a_d), .abort_fill_data(fd));
  secondary_bus_model sbm (.pclk, .serr_on, .perr_go, .abort_go, .abort_kind, .serr_n, .perr_n, .ma, .mq);
  function automatic logic fwd(input logic up, input word_t a, input word_t b);
    return up ? (a < b || a[9:8] != 0) : (a >= b && a[9:8] == 0);
  endfunction
  function automatic logic [2:0] aexp(input logic [2:0] k);
    return k[2:1] != 0 ? 3'h4 : k[0] ? 3'h2 : 3'h1;
  endfunction
  task automatic chk(input word_t got, input word_t exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input word_t d);
    int n;
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1 && n < 40);
    if (pready !== 1)
    begin
      n_mismatch++;
      summarize();
    end
    else
    begin
      rv = pslverr ? 32'h100 : prdata;
      psel <= 0;
      penable <= 0;
      repeat (2) @(posedge pclk);
    end
  endtask
  task automatic dec(input logic up, input logic io, input word_t a);
    dec_valid <= 1;
    dec_upstream <= up;
    dec_is_io <= io;
    dec_addr <= a;
    @(posedge pclk);
    dec_valid <= 0;
    @(posedge pclk);
    chk(dec_done, 1);
  endtask
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    for (i = 0; i < 4; i++)
    begin
      apb(0, ra[i], 0);
      chk(rv, rst_v[i]);
      apb(1, ra[i], 32'hffff_ffff);
      apb(0, ra[i], 0);
      chk(rv, ones_v[i]);
    end
    chk(srst_n, 0);
    apb(0, 12'h100, 0);
    chk(rv, 32'h100);
    wd = $random(seed);
    apb(1, 12'hc8, wd);
    apb(0, 12'hc8, 0);
    chk(rv, {16'h0, wd[15:0]});
    ee <= 1;
    apb(1, 12'hf8, 32'h0);
    apb(0, 12'hf8, 0);
    chk(rv, 32'h4);
    chk(srst_n, 1);
    ee <= 0;
    apb(1, 12'hf8, 32'h4);
    for (i = 0; i < 16; i++)
    begin
      rv = i < 2 ? 32'h2ff + i : $random(seed) & 32'hffff;
      io_base <= i < 8 ? 32'h0 : 32'h8000;
      dec(i[0], 1, rv);
      chk(dec_forward, fwd(i[0], rv, io_base));
    end
    for (i = 0; i < 3; i++)
    begin
      apb(1, 12'hf8, i == 2 ? 32'h0 : 32'h8);
      dec(0, i == 1, i == 1 ? 32'h3c0 : 32'ha0000 + ($random(seed) & 32'h1ffff));
      chk(dec_forward, i != 2);
    end
    apb(1, 12'h184, 32'h7);
    for (i = 0; i < 8; i++)
    begin
      apb(1, 12'hf8, {i[2], 5'h0});
      abort_go <= 1;
      abort_kind <= i[1:0];
      @(posedge pclk);
      abort_go <= 0;
      repeat (2) @(posedge pclk);
      chk({a_t, a_f, a_d}, aexp(i[2:0]));
      chk(fd, i[2:0] == 3'h1 ? 32'hffff_ffff : 32'h0);
    end
    apb(0, 12'h180, 0);
    chk(rv[2], 1);
    chk(irq, 1);
    for (i = 0; i < 4; i++)
    begin
      apb(1, 12'h180, 32'h7);
      apb(1, 12'hf8, 32'(i[0]) << i[1]);
      serr_on <= i[1];
      perr_go <= !i[1];
      @(posedge pclk);
      perr_go <= 0;
      repeat (6) @(posedge pclk);
      chk(pse_n, !(i[0] & i[1]));
      serr_on <= 0;
      apb(0, 12'h180, 0);
      chk(rv[0], i == 1);
    end
    apb(1, 12'h184, 32'h0);
    chk(irq, 0);
    summarize();
  end
endmodule

// file: test/bridge_regs_properties.sv
// assertions on the bridge control block ports
// assumes a bind onto the design top
`timescale 1ns/1ns
module bridge_regs_properties
#(
  parameter int ADDR_W = 12
)
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // side pins
  input wire logic secondary_system_error_in_n,
  input wire logic primary_system_error_out_n,
  input wire logic secondary_reset_output_n,
  input wire logic dec_valid,
  input wire logic dec_done,
  input wire logic sec_mabort,
  input wire logic sec_mabort_locked,
  input wire logic abort_target,
  input wire logic abort_fill,
  input wire logic [31:0] abort_fill_data
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic rd = pready && !pwrite;
  a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready");
  a_cap_ptr_fixed: assert property (rd && paddr == 12'hd0 |-> prdata == 32'hdc) else $error("cap");
  a_int_pin_zero: assert property (rd && paddr == 12'hf4 |-> prdata == 32'h0) else $error("pin");
  a_fast_b2b_zero: assert property (rd && paddr == 12'hf8 |-> !prdata[7]) else $error("b2b");
  a_srst_follows: assert property (pready && pwrite && paddr == 12'hf8
    |-> ##2 secondary_reset_output_n == !$past(pwdata[6], 2)) else $error("srst");
  a_serr_quiet: assert property (secondary_system_error_in_n [*5] |-> primary_system_error_out_n)
    else $error("serr");
  a_decode_answer: assert property (dec_valid |=> dec_done) else $error("dec");
  a_lock_target: assert property (sec_mabort && sec_mabort_locked |=> abort_target && !abort_fill)
    else $error("lock");
  a_fill_ones: assert property (abort_fill |-> abort_fill_data == 32'hffff_ffff) else $error("fill");
  c_lock_abort: cover property (sec_mabort && sec_mabort_locked);
  c_serr_out: cover property (!primary_system_error_out_n);
  c_srst_on: cover property (!secondary_reset_output_n);
endmodule
bind bridge_control_config_regs bridge_regs_properties #(.ADDR_W(ADDR_W)) props (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .secondary_system_error_in_n,
  .primary_system_error_out_n, .secondary_reset_output_n, .dec_valid, .dec_done, .sec_mabort,
  .sec_mabort_locked, .abort_target, .abort_fill, .abort_fill_data);

// file: test/secondary_bus_model.sv
// secondary bus model: error pins and abort reports
// assumes commands from the bench on pclk
`timescale 1ns/1ns
module secondary_bus_model
(
  // commands
  input wire logic pclk,
  input wire logic serr_on,
  input wire logic perr_go,
  input wire logic abort_go,
  input wire logic [1:0] abort_kind,
  // pins
  output logic serr_n = 1'b1,
  output logic perr_n = 1'b1,
  output logic ma = 1'b0,
  output logic [1:0] mq = 2'h0
);
  always @(posedge pclk)
  begin
    serr_n <= !serr_on;
    perr_n <= !perr_go;
    ma <= abort_go;
    // qualifiers change outside a report
    mq <= abort_go ? abort_kind : ~mq;
  end
endmodule
